// *** design/rcc_pkg.sv ***
/*
 Constants, tables and carrier types of the repeater configuration control.
 Assumes a 32-bit AHB-Lite register bus and four-level pins digitised
 into three-bit thermometer codes by the pad comparators.
*/
package rcc_pkg;
   localparam int LANES = 8;
   localparam int LW    = 14;
   localparam int CW    = 9;

   // Byte offsets; lane n sits at LANE0 + 4*n
   localparam logic [7:0] OFF_LANE0 = 8'h00;
   localparam logic [7:0] OFF_CTRL  = 8'h20;
   localparam logic [7:0] OFF_STAT  = 8'h24;

   typedef enum logic [1:0] {SRC_PIN, SRC_SLAVE, SRC_EEPROM} src_t;
   typedef enum logic [1:0] {RATE_GEN12, RATE_GEN3, RATE_AUTO} rate_t;
   typedef enum logic [1:0] {LV_LOW, LV_RES, LV_OPEN, LV_HIGH} level_t;
   typedef enum logic [1:0] {AK_LANE, AK_CTRL, AK_STAT, AK_NONE} akind_t;

   typedef struct packed {
      logic       term_dis;
      logic [1:0] dem;
      logic [2:0] swing;
      logic [7:0] eq;
   } lane_cfg_t;

   typedef struct packed {
      logic       load_done;
      logic       idle_ovr;
      logic [1:0] idle_th;
      logic       term_ovr;
      logic       term_auto;
      logic       rate_ovr;
      logic [1:0] rate;
   } ctrl_t;

   localparam lane_cfg_t LANE_RST = '0;
   localparam ctrl_t     CTRL_RST = '0;

   // Pin-mode tables indexed by {level1, level0}, entry 15 first
   localparam logic [15:0][7:0] EQ_TAB = {
      8'hff, 8'hbf, 8'h7f, 8'haa, 8'h3f, 8'h2f, 8'h1f, 8'h55,
      8'h0f, 8'h0b, 8'h15, 8'h07, 8'h03, 8'h02, 8'h01, 8'h00};
   // Swing code 0..5 for 0.8 V .. 1.3 V
   localparam logic [15:0][2:0] SWING_TAB = {
      3'h5, 3'h5, 3'h5, 3'h5, 3'h4, 3'h4, 3'h4, 3'h3,
      3'h3, 3'h3, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0};
   // De-emphasis code 0..3 for 0, -3.5, -6, -9 dB
   localparam logic [15:0][1:0] DEM_TAB = {
      2'h3, 2'h2, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0, 2'h2,
      2'h1, 2'h0, 2'h2, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0};
endpackage : rcc_pkg

// *** design/lane_store.sv ***
/*
 Per-lane configuration word store with a registered read port.
 Assumes one writer on hclk; clr wipes every word synchronously.
*/
`timescale 1ns/100ps
module lane_store #(
   parameter int WORDS = 8,
   parameter int W     = 14,
   parameter int AW    = 3
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     clr,
   input  wire logic                     we,
   input  wire logic [AW-1:0]            waddr,
   input  wire logic [W-1:0]             wdata,
   input  wire logic [AW-1:0]            raddr,
   output logic      [W-1:0]             rdata_q,
   output logic      [WORDS-1:0][W-1:0]  mem_q
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_q <= '0;
      end else if (clr) begin
         mem_q <= '0;
      end else if (we) begin
         mem_q[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= mem_q[raddr];
      end
   end
endmodule : lane_store

// *** design/repeater_config_control.sv ***
/*
 Configuration control of an eight-lane repeater: picks pin straps,
 bus-written registers or EEPROM-loaded registers as the source of
 equalization, swing, de-emphasis, termination and rate settings.
 Assumes one AHB-Lite master, pins digitised to thermometer codes
 (3'b000 low, 001 resistor, 011 open, 111 high) in another domain.
*/
`timescale 1ns/100ps
// How it works
// - Select strap picks pins when low, bus slave when high, EEPROM when open.
// - Pin mode takes boost and emphasis per side, A and B separately.
// - Pin mode sets swing from the same strap pair as de-emphasis.
// - Far termination strap selects automatic or manual termination control.
// - Rate strap selects first/second generation, automatic detect, or third generation.
// - Register modes program swing, boost, emphasis, termination disable per lane.
// - Raising the select strap high hands control to registers at once; open waits for the EEPROM load to be done.
// - In register modes boost and emphasis pins form the four-bit bus address.
// - Rate, termination, threshold pins obey unless register override bit is set.
// - Registers return to defaults at reset and while the strap is low.
// - Power down with strap high leaves register contents untouched.
// - Each lane holds an eight-bit boost value, 256 settings via registers.
// - Pin mode offers sixteen boost settings from two four-level pins.
// - Each four-level pin decodes to low, resistor, open or high.
// - Non-zero de-emphasis only applies in third generation rate mode.
module repeater_config_control #(
   parameter int LANES = rcc_pkg::LANES
) (
   input  wire logic                         hclk,
   input  wire logic                         hresetn,
   input  wire logic                         hsel,
   input  wire logic [31:0]                  haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output logic                              hreadyout,
   output logic      [31:0]                  hrdata,
   output logic                              hresp,
   input  wire logic [2:0]                   config_source_strap,
   input  wire logic [11:0]                  boost_select_pins,
   input  wire logic [11:0]                  emphasis_select_pins,
   input  wire logic                         far_termination_pin,
   input  wire logic [2:0]                   rate_mode_pin,
   input  wire logic [2:0]                   idle_threshold_pin,
   input  wire logic                         power_down_input,
   output rcc_pkg::lane_cfg_t [LANES-1:0]    lane_cfg_q,
   output rcc_pkg::rate_t                    rate_mode_q,
   output logic                              term_auto_q,
   output logic      [1:0]                   idle_th_q,
   output logic      [3:0]                   bus_address_straps,
   output rcc_pkg::src_t                     config_source_q,
   output logic                              power_down_q
);
   localparam int SW = 36;

   // Thermometer code to level; bubbles decode by their count of set bits (one is resistor, two is open)
   function automatic rcc_pkg::level_t decode4(input logic [2:0] t);
      rcc_pkg::level_t lv;
      lv = rcc_pkg::LV_LOW;
      case (t)
         3'h0: lv = rcc_pkg::LV_LOW;
         3'h1: lv = rcc_pkg::LV_RES;
         3'h3: lv = rcc_pkg::LV_OPEN;
         3'h7: lv = rcc_pkg::LV_HIGH;
         3'h2: lv = rcc_pkg::LV_RES;
         3'h4: lv = rcc_pkg::LV_RES;
         default: lv = rcc_pkg::LV_OPEN;
      endcase
      return lv;
   endfunction : decode4

   function automatic rcc_pkg::akind_t addr_kind(input logic [31:0] a);
      rcc_pkg::akind_t k;
      k = rcc_pkg::AK_NONE;
      if (a[31:8] != 24'h0 || a[1:0] != 2'h0) begin
         k = rcc_pkg::AK_NONE;
      end else if (a[7:0] == rcc_pkg::OFF_CTRL) begin
         k = rcc_pkg::AK_CTRL;
      end else if (a[7:0] == rcc_pkg::OFF_STAT) begin
         k = rcc_pkg::AK_STAT;
      end else if (a[7:0] >= rcc_pkg::OFF_LANE0 &&
                   a[7:0] < rcc_pkg::OFF_LANE0 + 8'(4 * LANES)) begin
         k = rcc_pkg::AK_LANE;
      end
      return k;
   endfunction : addr_kind

   // Two-flop synchronisers for every pin
   wire logic [SW-1:0] pins_raw = {config_source_strap, boost_select_pins,
                                   emphasis_select_pins, far_termination_pin,
                                   rate_mode_pin, idle_threshold_pin,
                                   power_down_input, 1'b0};
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   wire logic [2:0]  s_src   = sync2_q[35:33];
   wire logic [11:0] s_boost = sync2_q[32:21];
   wire logic [11:0] s_emph  = sync2_q[20:9];
   wire logic        s_term  = sync2_q[8];
   wire logic [2:0]  s_rate  = sync2_q[7:5];
   wire logic [2:0]  s_idle  = sync2_q[4:2];
   wire logic        s_pdn   = sync2_q[1];

   // Source selection
   wire rcc_pkg::level_t src_lv = decode4(s_src);
   rcc_pkg::src_t src;
   always_comb begin
      case (src_lv)
         rcc_pkg::LV_HIGH: src = rcc_pkg::SRC_SLAVE;
         rcc_pkg::LV_OPEN: src = rcc_pkg::SRC_EEPROM;
         default:          src = rcc_pkg::SRC_PIN;
      endcase
   end

   wire logic pin_mode = (src == rcc_pkg::SRC_PIN);
   // Power down is deliberately absent from the clear term
   wire logic regs_clr = pin_mode;

   // Bus address phase
   wire logic            take   = hsel && hready && htrans[1];
   wire rcc_pkg::akind_t a_kind = addr_kind(haddr);

   logic                  wr_pend_q;
   rcc_pkg::akind_t       wr_kind_q;
   logic [2:0]            wr_idx_q;
   logic                  rd1_q;
   logic                  rd2_q;
   rcc_pkg::akind_t       rd_kind_q;
   logic [2:0]            rd_idx_q;
   rcc_pkg::ctrl_t        ctrl_q;
   logic [rcc_pkg::LW-1:0]            lane_rd;
   logic [LANES-1:0][rcc_pkg::LW-1:0] lane_mem;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_kind_q <= rcc_pkg::AK_NONE;
         wr_idx_q  <= 3'h0;
         rd1_q     <= 1'b0;
         rd2_q     <= 1'b0;
         rd_kind_q <= rcc_pkg::AK_NONE;
         rd_idx_q  <= 3'h0;
      end else begin
         wr_pend_q <= take && hwrite;
         rd1_q     <= take && !hwrite;
         rd2_q     <= rd1_q;
         if (take && hwrite) begin
            wr_kind_q <= a_kind;
            wr_idx_q  <= haddr[4:2];
         end
         if (take && !hwrite) begin
            rd_kind_q <= a_kind;
            rd_idx_q  <= haddr[4:2];
         end
      end
   end

   // Writes land in the data phase; ignored while the pins rule
   wire logic lane_we = wr_pend_q && !pin_mode && wr_kind_q == rcc_pkg::AK_LANE;
   wire logic ctrl_we = wr_pend_q && !pin_mode && wr_kind_q == rcc_pkg::AK_CTRL;

   lane_store #(
      .WORDS (LANES),
      .W     (rcc_pkg::LW),
      .AW    (3)
   ) u_lanes (
      .clk     (hclk),
      .rst_n   (hresetn),
      .clr     (regs_clr),
      .we      (lane_we),
      .waddr   (wr_idx_q),
      .wdata   (hwdata[rcc_pkg::LW-1:0]),
      .raddr   (rd_idx_q),
      .rdata_q (lane_rd),
      .mem_q   (lane_mem)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= rcc_pkg::CTRL_RST;
      end else if (regs_clr) begin
         ctrl_q <= rcc_pkg::CTRL_RST;
      end else if (ctrl_we) begin
         ctrl_q <= rcc_pkg::ctrl_t'(hwdata[rcc_pkg::CW-1:0]);
      end
   end

   // Register path live in slave mode, or once the EEPROM load is done
   wire logic regs_live = (src == rcc_pkg::SRC_SLAVE) ||
                          (src == rcc_pkg::SRC_EEPROM && ctrl_q.load_done);

   // Global settings: pins obey until their override bit is set
   wire rcc_pkg::level_t rate_lv = decode4(s_rate);
   rcc_pkg::rate_t pin_rate;
   always_comb begin
      case (rate_lv)
         rcc_pkg::LV_LOW:  pin_rate = rcc_pkg::RATE_GEN12;
         rcc_pkg::LV_HIGH: pin_rate = rcc_pkg::RATE_GEN3;
         default:          pin_rate = rcc_pkg::RATE_AUTO;
      endcase
   end

   wire logic ovr_ok = !pin_mode;
   wire rcc_pkg::rate_t rate_d = (ovr_ok && ctrl_q.rate_ovr) ?
                                 rcc_pkg::rate_t'(ctrl_q.rate) : pin_rate;
   wire logic term_d = (ovr_ok && ctrl_q.term_ovr) ?
                       ctrl_q.term_auto : s_term;
   wire logic [1:0] idle_d = (ovr_ok && ctrl_q.idle_ovr) ?
                             ctrl_q.idle_th : 2'(decode4(s_idle));
   wire logic gen3 = (rate_d == rcc_pkg::RATE_GEN3);

   // Pin-mode settings per side: A drives the low half, B the high half
   wire rcc_pkg::level_t eq_a1 = decode4(s_boost[11:9]);
   wire rcc_pkg::level_t eq_a0 = decode4(s_boost[8:6]);
   wire rcc_pkg::level_t eq_b1 = decode4(s_boost[5:3]);
   wire rcc_pkg::level_t eq_b0 = decode4(s_boost[2:0]);
   wire rcc_pkg::level_t dm_a1 = decode4(s_emph[11:9]);
   wire rcc_pkg::level_t dm_a0 = decode4(s_emph[8:6]);
   wire rcc_pkg::level_t dm_b1 = decode4(s_emph[5:3]);
   wire rcc_pkg::level_t dm_b0 = decode4(s_emph[2:0]);

   wire logic [3:0] eq_ia = {eq_a1, eq_a0};
   wire logic [3:0] eq_ib = {eq_b1, eq_b0};
   wire logic [3:0] dm_ia = {dm_a1, dm_a0};
   wire logic [3:0] dm_ib = {dm_b1, dm_b0};

   rcc_pkg::lane_cfg_t pin_a;
   rcc_pkg::lane_cfg_t pin_b;
   always_comb begin
      pin_a.term_dis = 1'b0;
      pin_a.eq       = rcc_pkg::EQ_TAB[eq_ia];
      pin_a.swing    = rcc_pkg::SWING_TAB[dm_ia];
      pin_a.dem      = rcc_pkg::DEM_TAB[dm_ia];
      pin_b.term_dis = 1'b0;
      pin_b.eq       = rcc_pkg::EQ_TAB[eq_ib];
      pin_b.swing    = rcc_pkg::SWING_TAB[dm_ib];
      pin_b.dem      = rcc_pkg::DEM_TAB[dm_ib];
   end

   // Per-lane output selection
   rcc_pkg::lane_cfg_t [LANES-1:0] lane_d;
   genvar gi;
   generate
      for (gi = 0; gi < LANES; gi++) begin : g_lane
         rcc_pkg::lane_cfg_t base;
         always_comb begin
            if (regs_live) begin
               base = rcc_pkg::lane_cfg_t'(lane_mem[gi]);
            end else if (pin_mode) begin
               base = (gi < LANES / 2) ? pin_a : pin_b;
            end else begin
               base = rcc_pkg::LANE_RST;
            end
            lane_d[gi]     = base;
            lane_d[gi].dem = gen3 ? base.dem : 2'h0;
         end
      end
   endgenerate

   // Address straps only mean anything off pin mode
   wire logic [3:0] addr_d = pin_mode ? 4'h0 :
                             {s_emph[7], s_emph[10], s_boost[7], s_boost[10]};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lane_cfg_q         <= '0;
         rate_mode_q        <= rcc_pkg::RATE_GEN12;
         term_auto_q        <= 1'b0;
         idle_th_q          <= 2'h0;
         bus_address_straps <= 4'h0;
         config_source_q    <= rcc_pkg::SRC_PIN;
         power_down_q       <= 1'b0;
      end else begin
         lane_cfg_q         <= lane_d;
         rate_mode_q        <= rate_d;
         term_auto_q        <= term_d;
         idle_th_q          <= idle_d;
         bus_address_straps <= addr_d;
         config_source_q    <= src;
         power_down_q       <= s_pdn;
      end
   end

   // Read data: two wait states, the first for the store's read register
   wire logic [31:0] stat_word = {24'h0, 2'(rate_mode_q), regs_live,
                                  power_down_q, 2'(config_source_q), 2'h0};
   logic [31:0] rd_word;
   always_comb begin
      case (rd_kind_q)
         rcc_pkg::AK_LANE: rd_word = {{(32 - rcc_pkg::LW){1'b0}}, lane_rd};
         rcc_pkg::AK_CTRL: rd_word = {{(32 - rcc_pkg::CW){1'b0}}, ctrl_q};
         rcc_pkg::AK_STAT: rd_word = stat_word;
         default:          rd_word = 32'h0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hrdata    <= 32'h0;
         hresp     <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (take && !hwrite) begin
            hreadyout <= 1'b0;
         end else if (rd2_q) begin
            hreadyout <= 1'b1;
         end
         if (rd2_q) begin
            hrdata <= rd_word;
         end
      end
   end

   // Size is not checked: only word transfers are in use
   wire logic unused_ok = &{1'b0, hsize, hwdata[31:rcc_pkg::LW], sync2_q[0]};
endmodule : repeater_config_control

// *** test/config_checker.sv ***
/*
 Checker of the repeater configuration control, bound to its top module.
 Assumes pins digitised to thermometer codes and a three-edge pin latency.
*/
`timescale 1ns/100ps
module config_checker #(
   parameter int LANES = rcc_pkg::LANES
) (
   input wire logic                            hclk,
   input wire logic                            hresetn,
   input wire logic                            hsel,
   input wire logic [1:0]                      htrans,
   input wire logic                            hwrite,
   input wire logic                            hready,
   input wire logic                            hreadyout,
   input wire logic [2:0]                      config_source_strap,
   input wire logic [11:0]                     boost_select_pins,
   input wire logic [11:0]                     emphasis_select_pins,
   input wire logic                            far_termination_pin,
   input wire logic [2:0]                      rate_mode_pin,
   input wire rcc_pkg::lane_cfg_t [LANES-1:0]  lane_cfg_q,
   input wire rcc_pkg::rate_t                  rate_mode_q,
   input wire logic                            term_auto_q,
   input wire logic [3:0]                      bus_address_straps,
   input wire rcc_pkg::src_t                   config_source_q
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   function automatic logic [1:0] lvl(input logic [2:0] t);
      return 2'(t[0]) + 2'(t[1]) + 2'(t[2]);
   endfunction : lvl

   logic       pin_mode;
   logic [3:0] eq_a;
   logic [3:0] eq_b;
   logic [3:0] dm_a;
   logic [1:0] dem_any;
   assign pin_mode = config_source_q == rcc_pkg::SRC_PIN;
   assign eq_a     = {lvl(boost_select_pins[11:9]), lvl(boost_select_pins[8:6])};
   assign eq_b     = {lvl(boost_select_pins[5:3]), lvl(boost_select_pins[2:0])};
   assign dm_a     = {lvl(emphasis_select_pins[11:9]), lvl(emphasis_select_pins[8:6])};
   // Lag of one cycle between rate and lanes is tolerated below
   always_comb begin
      dem_any = 2'h0;
      for (int i = 0; i < LANES; i++) dem_any = dem_any | lane_cfg_q[i].dem;
   end

   AST_SRC: assert property ($stable(config_source_strap) [*5] |-> config_source_q ==
      (config_source_strap == 3'h7 ? rcc_pkg::SRC_SLAVE : config_source_strap == 3'h3 ? rcc_pkg::SRC_EEPROM
      : rcc_pkg::SRC_PIN)) else $error("source select wrong");
   AST_EQ_A: assert property ((pin_mode && $stable(boost_select_pins)) [*5] |->
      lane_cfg_q[0].eq == rcc_pkg::EQ_TAB[eq_a]) else $error("side A boost wrong");
   AST_EQ_B: assert property ((pin_mode && $stable(boost_select_pins)) [*5] |->
      lane_cfg_q[LANES-1].eq == rcc_pkg::EQ_TAB[eq_b]) else $error("side B boost wrong");
   AST_SWING: assert property ((pin_mode && $stable(emphasis_select_pins)) [*5] |->
      lane_cfg_q[0].swing == rcc_pkg::SWING_TAB[dm_a]) else $error("swing wrong");
   AST_DEM: assert property (rate_mode_q != rcc_pkg::RATE_GEN3 && $past(rate_mode_q) != rcc_pkg::RATE_GEN3
      |-> dem_any == 2'h0) else $error("emphasis outside gen3");
   AST_ADDR: assert property ((!pin_mode && $stable({boost_select_pins, emphasis_select_pins})) [*5] |->
      bus_address_straps == {emphasis_select_pins[7], emphasis_select_pins[10], boost_select_pins[7],
      boost_select_pins[10]}) else $error("address straps wrong");
   AST_ADDR_PIN: assert property (pin_mode && $past(pin_mode) |-> bus_address_straps == 4'h0)
      else $error("address straps in pin mode");
   AST_RATE: assert property ((pin_mode && $stable(rate_mode_pin)) [*5] |-> rate_mode_q ==
      (rate_mode_pin == 3'h0 ? rcc_pkg::RATE_GEN12 : rate_mode_pin == 3'h7 ? rcc_pkg::RATE_GEN3
      : rcc_pkg::RATE_AUTO)) else $error("rate mode wrong");
   AST_TERM: assert property ((pin_mode && $stable(far_termination_pin)) [*5] |->
      term_auto_q == far_termination_pin) else $error("termination control wrong");
   AST_RD_WAIT: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout [*2] ##1 hreadyout)
      else $error("read wait states wrong");
endmodule : config_checker

bind repeater_config_control config_checker #(.LANES(LANES)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .config_source_strap(config_source_strap), .boost_select_pins(boost_select_pins),
   .emphasis_select_pins(emphasis_select_pins), .far_termination_pin(far_termination_pin),
   .rate_mode_pin(rate_mode_pin), .lane_cfg_q(lane_cfg_q), .rate_mode_q(rate_mode_q),
   .term_auto_q(term_auto_q), .bus_address_straps(bus_address_straps), .config_source_q(config_source_q));

// *** test/strap_board.sv ***
/*
 Board strap model: four-level pins seen through the pad comparators.
 Assumes levels 0..3 mean low, resistor, open, high.
*/
`timescale 1ns/100ps
module strap_board (
   input  wire logic [1:0]  src_lvl,
   input  wire logic [7:0]  boost_lvl,
   input  wire logic [7:0]  emph_lvl,
   input  wire logic [1:0]  rate_lvl,
   input  wire logic [1:0]  idle_lvl,
   output logic      [2:0]  config_source_strap,
   output logic      [11:0] boost_select_pins,
   output logic      [11:0] emphasis_select_pins,
   output logic      [2:0]  rate_mode_pin,
   output logic      [2:0]  idle_threshold_pin
);
   // Comparator ladder yields a thermometer code
   function automatic logic [2:0] th(input logic [1:0] l);
      return {l == 2'h3, l >= 2'h2, l != 2'h0};
   endfunction : th
   function automatic logic [11:0] th4(input logic [7:0] l);
      return {th(l[7:6]), th(l[5:4]), th(l[3:2]), th(l[1:0])};
   endfunction : th4
   assign config_source_strap  = th(src_lvl);
   assign boost_select_pins    = th4(boost_lvl);
   assign emphasis_select_pins = th4(emph_lvl);
   assign rate_mode_pin        = th(rate_lvl);
   assign idle_threshold_pin   = th(idle_lvl);
endmodule : strap_board

// *** test/testbench.sv ***
/*
 Self-checking bench: AHB-Lite master, strap model, queue scoreboard.
 Assumes the design answers reads after two wait states.
*/
`timescale 1ns/100ps
module testbench;
   logic             hclk;
   logic             hresetn;
   logic             hsel;
   logic [31:0]      haddr;
   logic [1:0]       htrans;
   logic             hwrite;
   logic [31:0]      hwdata;
   logic             hreadyout;
   logic [31:0]      hrdata;
   logic             hresp;
   logic [2:0]       src_pins;
   logic [11:0]      boost_pins;
   logic [11:0]      emph_pins;
   logic [2:0]       rate_pins;
   logic [2:0]       idle_pins;
   logic             term_pin;
   logic             pd_pin;
   logic [1:0]       src_lvl, rate_lvl, idle_lvl;
   logic [7:0]       boost_lvl, emph_lvl;
   logic [7:0][13:0] lane_cfg_q;
   rcc_pkg::rate_t   rate_mode_q;
   logic             term_auto_q;
   logic [1:0]       idle_th_q;
   logic [3:0]       bus_address_straps;
   rcc_pkg::src_t    config_source_q;
   logic             power_down_q;
   logic             probe, probe_st, rd_dp;
   logic [2:0]       probe_lane;
   logic [31:0]      obs, got, ex;
   logic [31:0]      exp_q[$];
   logic [31:0]      wv[8];
   int               fails = 0;
   int               total_checks = 0;
   int               seed = 32'h4ce09827;

   assign obs = probe_st ? {20'h0, rate_mode_q, term_auto_q, idle_th_q, bus_address_straps, config_source_q,
                power_down_q} : {18'h0, lane_cfg_q[probe_lane]};

   repeater_config_control #(.LANES(8)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .config_source_strap(src_pins), .boost_select_pins(boost_pins),
      .emphasis_select_pins(emph_pins), .far_termination_pin(term_pin), .rate_mode_pin(rate_pins),
      .idle_threshold_pin(idle_pins), .power_down_input(pd_pin), .lane_cfg_q(lane_cfg_q),
      .rate_mode_q(rate_mode_q), .term_auto_q(term_auto_q), .idle_th_q(idle_th_q),
      .bus_address_straps(bus_address_straps), .config_source_q(config_source_q), .power_down_q(power_down_q));

   strap_board board (
      .src_lvl(src_lvl), .boost_lvl(boost_lvl), .emph_lvl(emph_lvl), .rate_lvl(rate_lvl), .idle_lvl(idle_lvl),
      .config_source_strap(src_pins), .boost_select_pins(boost_pins), .emphasis_select_pins(emph_pins),
      .rate_mode_pin(rate_pins), .idle_threshold_pin(idle_pins));

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask : tick

   // Bounded: a stuck slave ends the run
   task automatic wait_ready();
      for (int k = 0; k < 50; k++) begin
         @(posedge hclk);
         if (hreadyout === 1'b1) return;
      end
      fails++;
      finish_test();
   endtask : wait_ready

   // Read notes d as the expected data
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      if (!wr) exp_q.push_back(d);
      wait_ready();
   endtask : bus

   task automatic look(input logic s, input int ln, input logic [31:0] e);
      probe      <= 1'b1;
      probe_st   <= s;
      probe_lane <= 3'(ln);
      exp_q.push_back(e);
      @(posedge hclk);
      probe <= 1'b0;
      @(posedge hclk);
   endtask : look

   function automatic logic [31:0] st(input logic [1:0] r, input logic t, input logic [1:0] i,
                                      input logic [3:0] a, input logic [1:0] s, input logic p);
      return {20'h0, r, t, i, a, s, p};
   endfunction : st

   always @(posedge hclk) begin
      if ((rd_dp === 1'b1 && hreadyout === 1'b1) || probe === 1'b1) begin
         got = probe ? obs : hrdata;
         ex = exp_q.pop_front();
         total_checks++;
         if (got !== ex) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, ex);
         end
      end
      if (hsel && htrans[1] && hreadyout) rd_dp <= !hwrite;
      else if (hreadyout) rd_dp <= 1'b0;
   end

   initial begin
      hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0; hwdata = '0;
      src_lvl = 2'h0; boost_lvl = '0; emph_lvl = '0; rate_lvl = 2'h3; idle_lvl = 2'h0;
      term_pin = 1'b0; pd_pin = 1'b0; probe = 1'b0; probe_st = 1'b0; probe_lane = '0; rd_dp = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      tick(4);
      for (int i = 0; i < 16; i++) begin
         boost_lvl <= {4'(i), 4'(15 - i)};
         emph_lvl  <= {4'(i), 4'(15 - i)};
         tick(3);
         look(0, 0, {18'h0, 1'b0, rcc_pkg::DEM_TAB[i], rcc_pkg::SWING_TAB[i], rcc_pkg::EQ_TAB[i]});
         look(0, 7, {18'h0, 1'b0, rcc_pkg::DEM_TAB[15-i], rcc_pkg::SWING_TAB[15-i], rcc_pkg::EQ_TAB[15-i]});
      end
      $display("Test pin tables done");
      src_lvl <= 2'h1;
      for (int l = 0; l < 4; l++) begin
         rate_lvl <= 2'(l);
         idle_lvl <= 2'(l);
         term_pin <= l[0];
         tick(4);
         look(1, 0, st(l == 0 ? 2'h0 : l == 3 ? 2'h1 : 2'h2, l[0], 2'(l), 4'h0, 2'h0, 1'b0));
         if (l == 0) look(0, 0, {18'h0, 6'h05, 8'hff});
      end
      bus(1, 32'h0, 32'h3fff);
      bus(0, 32'h0, 32'h0);
      $display("Test pin controls done");
      boost_lvl <= 8'hd0;
      emph_lvl  <= 8'h20;
      tick(3);
      src_lvl <= 2'h3;
      tick(4);
      look(1, 0, st(2'h1, 1'b1, 2'h3, 4'h9, 2'h1, 1'b0));
      look(0, 0, 32'h0);
      for (int n = 0; n < 8; n++) begin
         wv[n] = $random(seed) & 32'h3fff;
         bus(1, 32'(4 * n), wv[n]);
      end
      for (int n = 0; n < 8; n++) begin
         bus(0, 32'(4 * n), wv[n]);
         look(0, n, wv[n]);
      end
      bus(0, 32'h30, 32'h0);
      $display("Test lane registers done");
      rate_lvl <= 2'h1;
      tick(4);
      look(1, 0, st(2'h2, 1'b1, 2'h3, 4'h9, 2'h1, 1'b0));
      bus(1, 32'h20, 32'hb4);
      bus(0, 32'h20, 32'hb4);
      rate_lvl <= 2'h3;
      idle_lvl <= 2'h0;
      tick(4);
      look(1, 0, st(2'h0, 1'b0, 2'h1, 4'h9, 2'h1, 1'b0));
      pd_pin <= 1'b1;
      tick(4);
      look(0, 2, wv[2] & 32'h27ff);
      $display("Test overrides done");
      src_lvl <= 2'h0;
      tick(4);
      src_lvl <= 2'h3;
      pd_pin  <= 1'b0;
      tick(4);
      bus(0, 32'h0, 32'h0);
      bus(0, 32'h20, 32'h0);
      look(1, 0, st(2'h1, 1'b1, 2'h0, 4'h9, 2'h1, 1'b0));
      src_lvl <= 2'h2;
      tick(4);
      bus(1, 32'h14, wv[5]);
      tick(3);
      look(0, 5, 32'h0);
      bus(1, 32'h20, 32'h100);
      tick(3);
      look(0, 5, wv[5]);
      look(1, 0, st(2'h1, 1'b1, 2'h0, 4'h9, 2'h2, 1'b0));
      $display("Test strap modes done");
      finish_test();
   end
endmodule : testbench
